// File: shared/pts_consts.svh
/*
 * constants of the telegram framer: clock, baud, led timing, crc, fifo.
 * assumes a 100 MHz core clock; included by the package and the rtl.
 */
`ifndef PTS_CONSTS_SVH
`define PTS_CONSTS_SVH

// ----------------------------------------------------------------
// clock and serial line
// ----------------------------------------------------------------
`define PTS_CLK_HZ 100000000
`define PTS_BAUD 115200
`define PTS_BIT_CYC (`PTS_CLK_HZ / `PTS_BAUD)
`define PTS_FRAME_BITS 10

// ----------------------------------------------------------------
// led and measurement period
// ----------------------------------------------------------------
`define PTS_PERIOD_MS 1000
`define PTS_LED_MS_PER_A 25
// one tick per centiampere of on-time
`define PTS_TICK_US (`PTS_LED_MS_PER_A * 1000 / 100)
`define PTS_TICK_CYC (`PTS_CLK_HZ / 1000000 * `PTS_TICK_US)
`define PTS_TICKS_PER_PERIOD (`PTS_PERIOD_MS * 1000 / `PTS_TICK_US)
`define PTS_LED_FULL_CA 4000

// ----------------------------------------------------------------
// telegram
// ----------------------------------------------------------------
`define PTS_TPL_LEN 307
`define PTS_DIGITS 55
`define PTS_TAIL_LAST 5
`define PTS_CRC_POLY 16'hA001
`define PTS_CRC_INIT 16'h0000
`define PTS_CHAR_HASH 8'h23
`define PTS_CHAR_ZERO 8'h30
`define PTS_CHAR_ALPHA 8'h37
`define PTS_CHAR_CR 8'h0D
`define PTS_CHAR_LF 8'h0A
`define PTS_FIFO_DEPTH 16

`endif

// File: shared/pts_pkg.sv
/*
 * types and the telegram template of the framer.
 * assumes pts_consts.svh is on the include path.
 */
`include "pts_consts.svh"

package pts_pkg;

	// ----------------------------------------------------------------
	// measurement snapshot, five bcd digits per value, msd first
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [0:1][19:0] tot;
		logic [0:2][19:0] cur;
		logic [0:2][19:0] imp;
		logic [0:2][19:0] expo;
	} pts_meas_type;

	typedef enum logic [1:0] {GEN_IDLE, GEN_BODY, GEN_TAIL} pts_gen_type;
	typedef enum logic {UT_IDLE, UT_SEND} pts_uart_type;

	// ----------------------------------------------------------------
	// template, each # takes the next snapshot digit
	// ----------------------------------------------------------------
	// header id text is arbitrary
	localparam logic [8*`PTS_TPL_LEN-1:0] PTS_TEMPLATE = {
		"/ABC5P1FRAME\015\012\015\012",
		"1-3:0.2.8(50)\015\012",
		"1-0:1.8.1(000000.000*kWh)\015\012",
		"1-0:1.7.0(##.###*kW)\015\012",
		"1-0:2.7.0(##.###*kW)\015\012",
		"1-0:31.7.0(###.##*A)\015\012",
		"1-0:51.7.0(###.##*A)\015\012",
		"1-0:71.7.0(###.##*A)\015\012",
		"1-0:21.7.0(##.###*kW)\015\012",
		"1-0:41.7.0(##.###*kW)\015\012",
		"1-0:61.7.0(##.###*kW)\015\012",
		"1-0:22.7.0(##.###*kW)\015\012",
		"1-0:42.7.0(##.###*kW)\015\012",
		"1-0:62.7.0(##.###*kW)\015\012",
		"!"
	};

endpackage

// File: rtl/pts_fifo.sv
/*
 * synchronous fifo with valid/ready on both sides.
 * assumes one clock; depth is a power of two.
 */
`timescale 1ns/100ps

module pts_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// clock and control
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_ce,
	// filling side
	input wire logic i_in_valid,
	input wire logic [W-1:0] i_in_data,
	output logic o_in_ready,
	// draining side
	output logic o_out_valid,
	output logic [W-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic full, empty, push, pop;

	// extra pointer bit tells full from empty
	always_comb begin
		full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
		empty = (wp_r == rp_r);
		o_in_ready = !full;
		o_out_valid = !empty;
		o_out_data = mem[rp_r[AW-1:0]];
		push = i_in_valid && !full;
		pop = i_out_ready && !empty;
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			wp_r <= '0;
			rp_r <= '0;
		end else if (i_ce) begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
		end
	end

	// storage has no reset, only written entries are read
	always_ff @(posedge i_clk) begin
		if (i_ce && push) begin
			mem[wp_r[AW-1:0]] <= i_in_data;
		end
	end

endmodule

// File: rtl/pts_uart_tx.sv
/*
 * character transmitter, 8 data bits, no parity, one stop bit.
 * assumes the caller holds data stable while valid and not ready.
 */
`timescale 1ns/100ps
`include "pts_consts.svh"

module pts_uart_tx
	import pts_pkg::*;
(
	// clock and control
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_ce,
	// character in
	input wire logic i_valid,
	input wire logic [7:0] i_data,
	output logic o_ready,
	// line level, 1 is mark
	output logic o_line
);
	localparam logic [9:0] BIT_LAST = 10'(`PTS_BIT_CYC - 1);
	localparam logic [3:0] FRAME_LAST = 4'(`PTS_FRAME_BITS - 1);

	pts_uart_type st_r, st_nxt;
	logic [9:0] sh_r, sh_nxt;
	logic [9:0] baud_r, baud_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic line_r, line_nxt;

	// frame is start, lsb first data, stop
	always_comb begin
		st_nxt = st_r;
		sh_nxt = sh_r;
		baud_nxt = baud_r;
		bit_nxt = bit_r;
		line_nxt = line_r;
		o_ready = (st_r == UT_IDLE);
		case (st_r)
			UT_IDLE: begin
				line_nxt = 1'b1;
				if (i_valid) begin
					sh_nxt = {1'b1, i_data, 1'b0};
					baud_nxt = '0;
					bit_nxt = '0;
					line_nxt = 1'b0;
					st_nxt = UT_SEND;
				end
			end
			UT_SEND: begin
				baud_nxt = baud_r + 1'b1;
				if (baud_r == BIT_LAST) begin
					baud_nxt = '0;
					bit_nxt = bit_r + 1'b1;
					sh_nxt = {1'b1, sh_r[9:1]};
					line_nxt = sh_r[1];
					if (bit_r == FRAME_LAST) begin
						line_nxt = 1'b1;
						st_nxt = UT_IDLE;
					end
				end
			end
			default: st_nxt = UT_IDLE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			st_r <= UT_IDLE;
			sh_r <= '1;
			baud_r <= '0;
			bit_r <= '0;
			line_r <= 1'b1;
		end else if (i_ce) begin
			st_r <= st_nxt;
			sh_r <= sh_nxt;
			baud_r <= baud_nxt;
			bit_r <= bit_nxt;
			line_r <= line_nxt;
		end
	end

	assign o_line = line_r;

endmodule

// File: rtl/pts_top.sv
/*
 * telegram framer and status leds of a three-phase current sensor.
 * once per second, while data is requested, a text telegram is built from the latest measurement
 * snapshot, pushed through a fifo and sent on an open-collector line.
 * assumes bcd measurement values from the front end, all inputs
 * synchronous to I_CORE_CLK, and a pull-up on the data line.
 */
// Behaviour
// - line runs at 115200 baud, 8 data bits, no parity, 1 stop.
// - current led repeats a one-second cycle, one on then one off.
// - current led lit 25 ms per ampere of summed current.
// - summed current above 40 A keeps current led lit.
// - no current measured keeps current led dark all cycle.
// - request led follows the data-request input level.
// - unmeasured objects still sent with zero value.
// - version object 1-3:0.2.8 carries a two-character value.
// - per-phase currents with three integer, two fraction digits.
// - import power total in kW, five digits, three fractional.
// - export power total uses same five-digit kW format.
// - per-phase import power objects in kW, three fractional.
// - per-phase export power objects starting with 22.7.0.
// - new telegram at end of each one-second cycle while request is high.
`timescale 1ns/100ps
`include "pts_consts.svh"

module pts_top
	import pts_pkg::*;
#(
	parameter int P_TICK_CYC = `PTS_TICK_CYC
) (
	// clock, reset, enable
	input wire logic I_CORE_CLK,
	input wire logic I_RESETN,
	input wire logic I_CE,
	// measurement front end
	input wire logic I_MEAS_VALID,
	input wire pts_pkg::pts_meas_type I_MEAS,
	// p1 port
	input wire logic I_P1_REQ,
	input wire logic I_P1_DATA_IN,
	output logic O_P1_DATA_OUT,
	output logic O_P1_DATA_OE_N,
	// leds
	output logic O_POWER_INDICATOR_LED,
	output logic O_CURRENT_LED,
	output logic O_REQ_LED
);
	import pts_pkg::*;

	localparam int FLAT_W = 4 * `PTS_DIGITS;
	localparam logic [14:0] TICK_LAST = 15'(P_TICK_CYC - 1);
	localparam logic [11:0] PERIOD_LAST = 12'(`PTS_TICKS_PER_PERIOD - 1);
	localparam logic [18:0] LED_FULL = 19'(`PTS_LED_FULL_CA);
	localparam logic [8:0] TPL_LAST = 9'(`PTS_TPL_LEN - 1);
	localparam logic [2:0] TAIL_LAST = 3'(`PTS_TAIL_LAST);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// five bcd digits to centiamperes
	function automatic logic [16:0] bcd5_bin(input logic [19:0] b);
		logic [16:0] s;
		s = 17'(b[19:16]) * 17'd10000;
		s = s + 17'(b[15:12]) * 17'd1000;
		s = s + 17'(b[11:8]) * 17'd100;
		s = s + 17'(b[7:4]) * 17'd10;
		s = s + 17'(b[3:0]);
		return s;
	endfunction

	// reflected crc16, one character at a time
	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `PTS_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// upper-case hex digit
	function automatic logic [7:0] hex_char(input logic [3:0] n);
		logic [7:0] r;
		r = (n < 4'hA) ? (`PTS_CHAR_ZERO + {4'h0, n}) :
			(`PTS_CHAR_ALPHA + {4'h0, n});
		return r;
	endfunction

	// ----------------------------------------------------------------
	// measurement capture
	// ----------------------------------------------------------------
	pts_meas_type meas_r, meas_nxt;
	logic [18:0] total_r, total_nxt;

	// sum of phase currents kept in centiamperes for the led
	always_comb begin
		meas_nxt = meas_r;
		total_nxt = total_r;
		if (I_MEAS_VALID) begin
			meas_nxt = I_MEAS;
			total_nxt = 19'(bcd5_bin(I_MEAS.cur[0])) +
				19'(bcd5_bin(I_MEAS.cur[1])) +
				19'(bcd5_bin(I_MEAS.cur[2]));
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESETN) begin
			meas_r <= '0;
			total_r <= '0;
		end else if (I_CE) begin
			meas_r <= meas_nxt;
			total_r <= total_nxt;
		end
	end

	// ----------------------------------------------------------------
	// one-second period in 250 us ticks
	// ----------------------------------------------------------------
	logic [14:0] pre_r, pre_nxt;
	logic [11:0] tick_r, tick_nxt;
	logic tick, period_end;

	// one tick per centiampere of led on-time
	always_comb begin
		tick = (pre_r == TICK_LAST);
		period_end = tick && (tick_r == PERIOD_LAST);
		pre_nxt = tick ? '0 : pre_r + 1'b1;
		tick_nxt = tick_r;
		if (tick) begin
			tick_nxt = period_end ? '0 : tick_r + 1'b1;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESETN) begin
			pre_r <= '0;
			tick_r <= '0;
		end else if (I_CE) begin
			pre_r <= pre_nxt;
			tick_r <= tick_nxt;
		end
	end

	// ----------------------------------------------------------------
	// leds
	// ----------------------------------------------------------------
	logic cur_led_r, cur_led_nxt, req_led_r, req_led_nxt;

	// lit from period start for total_r ticks, then dark
	always_comb begin
		cur_led_nxt = ({7'h00, tick_r} < total_r);
		if (total_r > LED_FULL) begin
			cur_led_nxt = 1'b1;
		end
		req_led_nxt = I_P1_REQ;
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESETN) begin
			cur_led_r <= 1'b0;
			req_led_r <= 1'b0;
		end else if (I_CE) begin
			cur_led_r <= cur_led_nxt;
			req_led_r <= req_led_nxt;
		end
	end

	// ----------------------------------------------------------------
	// telegram generator
	// ----------------------------------------------------------------
	pts_gen_type gst_r, gst_nxt;
	pts_meas_type snap_r, snap_nxt;
	logic [FLAT_W-1:0] snap_flat;
	logic [8:0] idx_r, idx_nxt;
	logic [5:0] dptr_r, dptr_nxt;
	logic [2:0] tail_r, tail_nxt;
	logic [15:0] crc_r, crc_nxt;
	logic [7:0] tpl_char, dig_char, push_data;
	logic push_valid, push_ready;

	// template char and the digit that a # stands for
	always_comb begin
		snap_flat = snap_r;
		tpl_char = PTS_TEMPLATE[8 * (TPL_LAST - idx_r) +: 8];
		dig_char = `PTS_CHAR_ZERO +
			{4'h0, snap_flat[FLAT_W - 1 - 4 * dptr_r -: 4]};
	end

	// one character per accepted push; a frozen snapshot keeps the
	// telegram consistent even if a measurement lands mid-send
	always_comb begin
		gst_nxt = gst_r;
		snap_nxt = snap_r;
		idx_nxt = idx_r;
		dptr_nxt = dptr_r;
		tail_nxt = tail_r;
		crc_nxt = crc_r;
		push_valid = 1'b0;
		push_data = 8'h00;
		case (gst_r)
			GEN_IDLE: begin
				if (period_end && I_P1_REQ) begin
					snap_nxt = meas_r;
					idx_nxt = '0;
					dptr_nxt = '0;
					crc_nxt = `PTS_CRC_INIT;
					gst_nxt = GEN_BODY;
				end
			end
			GEN_BODY: begin
				push_valid = 1'b1;
				push_data = (tpl_char == `PTS_CHAR_HASH) ? dig_char :
					tpl_char;
				if (push_ready) begin
					crc_nxt = crc_step(crc_r, push_data);
					idx_nxt = idx_r + 1'b1;
					if (tpl_char == `PTS_CHAR_HASH) begin
						dptr_nxt = dptr_r + 1'b1;
					end
					if (idx_r == TPL_LAST) begin
						tail_nxt = '0;
						gst_nxt = GEN_TAIL;
					end
				end
			end
			GEN_TAIL: begin
				push_valid = 1'b1;
				// crc hex msd first, then line end
				case (tail_r)
					3'd0: push_data = hex_char(crc_r[15:12]);
					3'd1: push_data = hex_char(crc_r[11:8]);
					3'd2: push_data = hex_char(crc_r[7:4]);
					3'd3: push_data = hex_char(crc_r[3:0]);
					3'd4: push_data = `PTS_CHAR_CR;
					default: push_data = `PTS_CHAR_LF;
				endcase
				if (push_ready) begin
					tail_nxt = tail_r + 1'b1;
					if (tail_r == TAIL_LAST) begin
						gst_nxt = GEN_IDLE;
					end
				end
			end
			default: gst_nxt = GEN_IDLE;
		endcase
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESETN) begin
			gst_r <= GEN_IDLE;
			snap_r <= '0;
			idx_r <= '0;
			dptr_r <= '0;
			tail_r <= '0;
			crc_r <= `PTS_CRC_INIT;
		end else if (I_CE) begin
			gst_r <= gst_nxt;
			snap_r <= snap_nxt;
			idx_r <= idx_nxt;
			dptr_r <= dptr_nxt;
			tail_r <= tail_nxt;
			crc_r <= crc_nxt;
		end
	end

	// ----------------------------------------------------------------
	// fifo and transmitter
	// ----------------------------------------------------------------
	logic fifo_valid, tx_ready, tx_line;
	logic [7:0] fifo_data;

	// the generator outruns the line, so the fifo fills and stalls it
	pts_fifo #(
		.W(8),
		.D(`PTS_FIFO_DEPTH)
	) u_fifo (
		.i_clk(I_CORE_CLK),
		.i_resetn(I_RESETN),
		.i_ce(I_CE),
		.i_in_valid(push_valid),
		.i_in_data(push_data),
		.o_in_ready(push_ready),
		.o_out_valid(fifo_valid),
		.o_out_data(fifo_data),
		.i_out_ready(tx_ready)
	);

	pts_uart_tx u_tx (
		.i_clk(I_CORE_CLK),
		.i_resetn(I_RESETN),
		.i_ce(I_CE),
		.i_valid(fifo_valid),
		.i_data(fifo_data),
		.o_ready(tx_ready),
		.o_line(tx_line)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// open collector: pull low for space, release for mark and idle;
	// the line is never read back, I_P1_DATA_IN is left unused
	assign O_P1_DATA_OUT = 1'b0;
	assign O_P1_DATA_OE_N = tx_line;
	assign O_POWER_INDICATOR_LED = 1'b1; // lit whenever powered
	assign O_CURRENT_LED = cur_led_r;
	assign O_REQ_LED = req_led_r;

endmodule

// File: sim/pts_top_chk.sv
/*
 * port assertions of the telegram framer.
 * assumes it is bound to pts_top and sees one clock.
 */
`timescale 1ns/100ps

module pts_top_chk
	import pts_pkg::*;
#(
	parameter int P_TICK_CYC = 4
) (
	// clock, reset, inputs
	input wire logic I_CORE_CLK,
	input wire logic I_RESETN,
	input wire logic I_CE,
	input wire logic I_MEAS_VALID,
	input wire pts_pkg::pts_meas_type I_MEAS,
	input wire logic I_P1_REQ,
	// outputs
	input wire logic O_P1_DATA_OUT,
	input wire logic O_P1_DATA_OE_N,
	input wire logic O_CURRENT_LED,
	input wire logic O_REQ_LED
);
	localparam int PER = P_TICK_CYC * 4000;
	localparam int BIT = 100000000 / 115200;
	int sum_r;
	int pc_r;
	int lo_r;
	int hi_r;
	int rq_r;
	logic [2:0] age_r;

	function automatic int bcd5(logic [19:0] v);
		return v[19:16] * 10000 + v[15:12] * 1000 + v[11:8] * 100
			+ v[7:4] * 10 + v[3:0];
	endfunction

	// period phase, line run lengths, request and measurement age;
	// frozen with the design while the clock enable is low
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESETN) begin
			pc_r <= 0;
			lo_r <= 0;
			hi_r <= 20000;
			rq_r <= 99;
			sum_r <= 0;
			age_r <= 3'h7;
		end else if (I_CE) begin
			pc_r <= (pc_r == PER - 1) ? 0 : pc_r + 1;
			lo_r <= O_P1_DATA_OE_N ? 0 : lo_r + 1;
			hi_r <= !O_P1_DATA_OE_N ? 0 : (hi_r < 20000 ? hi_r + 1 : hi_r);
			rq_r <= I_P1_REQ ? 0 : (rq_r < 99 ? rq_r + 1 : rq_r);
			if (I_MEAS_VALID) begin
				sum_r <= bcd5(I_MEAS.cur[0]) + bcd5(I_MEAS.cur[1])
					+ bcd5(I_MEAS.cur[2]);
				age_r <= 3'h0;
			end else if (age_r != 3'h7) begin
				age_r <= age_r + 3'h1;
			end
		end
	end

	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (!I_RESETN);

	a_req_led_follow:
		assert property ($past(I_RESETN) && $past(I_CE)
			|-> O_REQ_LED == $past(I_P1_REQ))
		else $error("request led does not follow request");
	a_reset_idle:
		assert property ($rose(I_RESETN) |-> O_P1_DATA_OE_N && !O_CURRENT_LED
			&& !O_REQ_LED) else $error("outputs not idle after reset");
	a_drive_low:
		assert property (!O_P1_DATA_OE_N |-> !O_P1_DATA_OUT)
		else $error("data line driven high");
	a_bit_width:
		assert property ($rose(O_P1_DATA_OE_N) |-> lo_r % BIT == 0
			&& lo_r <= 9 * BIT) else $error("low run not whole bits");
	a_start_req:
		assert property ($fell(O_P1_DATA_OE_N) && hi_r > 10000 |-> rq_r < 8)
		else $error("telegram began without request");
	a_led_dark:
		assert property (age_r > 3'h2 && sum_r == 0 |-> !O_CURRENT_LED)
		else $error("led lit at zero current");
	a_led_full:
		assert property (age_r > 3'h2 && sum_r > 4000 |-> O_CURRENT_LED)
		else $error("led dark above full scale");
	a_led_rise:
		assert property ($rose(O_CURRENT_LED) |-> pc_r < 4 || pc_r > PER - 3
			|| age_r < 3'h4) else $error("led lit away from period start");
	a_led_fall:
		assert property ($fell(O_CURRENT_LED) && age_r > 3'h3
			|-> pc_r >= sum_r * P_TICK_CYC - 2
			&& pc_r <= sum_r * P_TICK_CYC + 3)
		else $error("led on time wrong");
endmodule

// File: sim/pts_p1_reader.sv
/*
 * reader at the far end of the data line: asks, decodes 8N1.
 * assumes the bench resolves the pulled-up line for it.
 */
`timescale 1ns/100ps

module pts_p1_reader #(
	parameter int BIT = 100000000 / 115200,
	parameter int HOLD = 5000
) (
	// clock and line
	input wire logic i_clk,
	input wire logic i_line,
	// request
	input wire logic i_want,
	output logic o_req,
	// decoded characters
	output logic o_rx_valid,
	output logic [7:0] o_rx_byte,
	output logic o_rx_err
);
	int hold = 0;

	// request dropped for a while once a telegram end is seen
	always @(posedge i_clk) begin
		if (o_rx_valid && o_rx_byte == 8'h21) begin
			hold <= HOLD;
		end else if (hold > 0) begin
			hold <= hold - 1;
		end
		o_req <= i_want && hold == 0;
	end

	// sample on falling edges, clear of the line's own edges
	initial begin
		o_rx_valid = 1'b0;
		o_rx_byte = 8'h00;
		o_rx_err = 1'b0;
		forever begin
			@(negedge i_clk);
			o_rx_valid = 1'b0;
			if (!i_line) begin
				repeat (BIT / 2) @(negedge i_clk);
				o_rx_err = i_line;
				for (int i = 0; i < 8; i++) begin
					repeat (BIT) @(negedge i_clk);
					o_rx_byte[i] = i_line;
				end
				repeat (BIT) @(negedge i_clk);
				o_rx_err = o_rx_err | !i_line;
				o_rx_valid = 1'b1;
			end
		end
	end
endmodule

// File: sim/pts_top_tb.sv
/*
 * self-checking bench of the telegram framer.
 * assumes reader model and checker are compiled first.
 */
`timescale 1ns/100ps

module pts_top_tb;
	import pts_pkg::*;
	localparam int P_TICK = 2;
	localparam int PER = P_TICK * 4000;
	localparam int CHAR = 10 * (100000000 / 115200);
	logic clk;
	logic resetn = 1'b0;
	logic ce = 1'b1;
	logic meas_valid = 1'b0;
	pts_meas_type meas = '0;
	logic want = 1'b0;
	logic req, p1_line, data_out, oe_n, pwr_led, cur_led, req_led;
	logic rx_valid, rx_err;
	logic [7:0] rx_byte;
	logic [7:0] rx_q[$];
	int frame_errs = 0;
	int num_errors = 0;
	int n_checks = 0;

	// open-collector wire with pull-up
	assign p1_line = oe_n ? 1'b1 : data_out;

	pts_top #(.P_TICK_CYC(P_TICK)) uut (
		.I_CORE_CLK(clk), .I_RESETN(resetn), .I_CE(ce),
		.I_MEAS_VALID(meas_valid), .I_MEAS(meas), .I_P1_REQ(req),
		.I_P1_DATA_IN(p1_line), .O_P1_DATA_OUT(data_out),
		.O_P1_DATA_OE_N(oe_n), .O_POWER_INDICATOR_LED(pwr_led),
		.O_CURRENT_LED(cur_led), .O_REQ_LED(req_led)
	);

	pts_p1_reader u_reader (
		.i_clk(clk), .i_line(p1_line), .i_want(want), .o_req(req),
		.o_rx_valid(rx_valid), .o_rx_byte(rx_byte), .o_rx_err(rx_err)
	);

	// clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// collect decoded characters
	always @(posedge clk) begin
		if (rx_valid) begin
			rx_q.push_back(rx_byte);
			frame_errs += rx_err;
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask

	task automatic put_cur(input logic [19:0] a, input logic [19:0] b,
		input logic [19:0] c);
		meas = '0;
		meas.cur[0] = a;
		meas.cur[1] = b;
		meas.cur[2] = c;
		meas_valid = 1'b1;
		cyc(1);
		meas_valid = 1'b0;
		cyc(3);
	endtask

	// lit cycles, lighting edges and line use over a window
	task automatic led_run(input int n, output int hi, output int rises,
		output int lows);
		logic prev;
		hi = 0;
		rises = 0;
		lows = 0;
		prev = cur_led;
		repeat (n) begin
			cyc(1);
			hi += cur_led;
			rises += (cur_led && !prev);
			lows += !oe_n;
			prev = cur_led;
		end
	endtask

	task automatic wait_rx(input int k, input int lim);
		int n;
		n = 0;
		while (rx_q.size() < k && n < lim) begin
			cyc(1);
			n++;
		end
	endtask

	task automatic t_reset();
		cyc(20);
		check("oe_n", 1, oe_n);
		check("current led", 0, cur_led);
		check("data out", 0, data_out);
		check("power led", 1, pwr_led);
		resetn = 1'b1;
		cyc(2);
		$display("test reset done");
	endtask

	task automatic t_req_led();
		want = 1'b1;
		cyc(1);
		check("req led early", 0, req_led);
		cyc(1);
		check("req led on", 1, req_led);
		want = 1'b0;
		cyc(2);
		check("req led off", 0, req_led);
		$display("test request led done");
	endtask

	// a low clock enable must freeze the request led
	task automatic t_ce();
		ce = 1'b0;
		want = 1'b1;
		cyc(3);
		check("req led frozen", 0, req_led);
		ce = 1'b1;
		cyc(2);
		check("req led thawed", 1, req_led);
		want = 1'b0;
		cyc(2);
		check("req led after", 0, req_led);
		$display("test clock enable done");
	endtask

	task automatic t_led();
		int hi;
		int rises;
		int lows;
		led_run(PER, hi, rises, lows);
		check("dark on time", 0, hi);
		check("line use", 0, lows);
		put_cur(20'h00333, 20'h00333, 20'h00334);
		led_run(2 * PER, hi, rises, lows);
		check("on time", 2 * 1000 * P_TICK, hi);
		check("flashes", 2, rises);
		check("line use", 0, lows);
		put_cur(20'h01334, 20'h01334, 20'h01333);
		led_run(PER, hi, rises, lows);
		check("full on time", PER, hi);
		put_cur(20'h00000, 20'h00000, 20'h00000);
		$display("test current led done");
	endtask

	// request dropped after the first character must not cut the send
	task automatic t_telegram();
		string hdr;
		hdr = "/ABC";
		want = 1'b1;
		wait_rx(1, PER + 2 * CHAR);
		check("first count", 1, rx_q.size());
		want = 1'b0;
		wait_rx(4, 4 * CHAR);
		check("char count", 4, rx_q.size());
		for (int i = 0; i < 4 && i < rx_q.size(); i++) begin
			check("header char", hdr[i], rx_q[i]);
		end
		check("stop bits", 0, frame_errs);
		$display("test telegram done");
	endtask

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		t_reset();
		t_req_led();
		t_ce();
		t_led();
		t_telegram();
		end_of_test();
	end

	// watchdog, about a third above the expected run
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		$display("unexpected run: expected end, seen timeout");
		end_of_test();
	end
endmodule

bind pts_top pts_top_chk #(.P_TICK_CYC(P_TICK_CYC)) u_chk (
	.I_CORE_CLK(I_CORE_CLK), .I_RESETN(I_RESETN), .I_CE(I_CE),
	.I_MEAS_VALID(I_MEAS_VALID), .I_MEAS(I_MEAS), .I_P1_REQ(I_P1_REQ),
	.O_P1_DATA_OUT(O_P1_DATA_OUT), .O_P1_DATA_OE_N(O_P1_DATA_OE_N),
	.O_CURRENT_LED(O_CURRENT_LED), .O_REQ_LED(O_REQ_LED)
);
